// *** src/vbs_top.v ***
// Functional notes
// R1 - Normal results: baseline table code 0-7 selects group bank bit via multiplexer.
// R2 - Tape validity map code triggers second lookup of point number to code.
// R3 - Front validity table holds all 256 tape points plus pulsar entries.
// R4 - Front validity address is 8-bit result joined with map code low bit.
// R5 - Map code low bit: 8 picks tape half, 9 picks pulsar half.
// R6 - Single pulsar group: loader fills all pulsar entries with one code.
// R7 - Tape validity code follows real baseline, equal to result 0-209.
// R8 - Back validity table 2K deep, address result bits 10:1 plus map low bit.
// R9 - Back reader may override automatic validity bank with its own bit.
// R10 - Back tape reads use even map code; code depends on result bits 10:3.
// R11 - Back pulsar reads use odd map code; same code for all baselines.
// R12 - Loader keeps front result translation pass-through for validities.
// R13 - Each of 256 epochs steps baselines 0-212, eight results each.
// R14 - Tape epoch n lands at locations 8n to 8n+7; epochs 210+ are junk.
// R15 - Pulsar validities lie on point axis of baselines 211 and 212.
// R16 - Pulsar location bits 2:1 give rack, bit 0 picks rack entry.
// R17 - Racks: 0,1 channels 0-3; 2,3 channels 4-7; odd racks stations 10-19.
// R18 - Each rack card keeps 256 counters per channel, four channels.
// R19 - Several pulsar groups share one dump rate, so one bank per set.
// R20 - Two pulsar groups split stations 0-9 and 10-19 across racks.
// R21 - Eight-bit bank and clear-accumulate registers, one bit per code.
// R22 - Back input may disable automatic bank, using address bank bit.
// R23 - Validity tables give 3-bit code into the same bank multiplexer.
// R24 - Processor loads tables before observation, consistent with grouping.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vbs_defs.vh"

module vbs_top (
	input wire clock, // System clock, 40 MHz
	input wire sys_rst, // Asynchronous reset, active high
	input wire [3:0] reg_addr, // Register word address
	input wire [15:0] reg_wdata, // Register write data
	input wire reg_wr, // Register write strobe
	input wire reg_rd, // Register read strobe
	output reg [15:0] reg_rdata_ff, // Read data, cycle after strobe
	input wire interval_tick, // Start of integration interval
	input wire fe_valid, // Front result present
	input wire [7:0] fe_baseline, // Front baseline number
	input wire [7:0] fe_result, // Front result (point) number
	input wire [2:0] fe_array, // Front array number
	output reg fe_out_valid_ff, // Front answer valid
	output reg fe_bank_ff, // Selected bank bit
	output reg fe_clear_accumulate_ff, // Clear-accumulate for result
	output reg [2:0] validity_accum_code_ff, // Code used for bank
	output reg [10:0] fe_loc_ff, // Storage location in baseline
	output reg fe_validity_ff, // Result is a validity
	output reg fe_pulsar_ff, // Result is a pulsar validity
	output reg [1:0] fe_rack_ff, // Pulsar source rack
	output reg fe_entry_ff, // Pulsar entry within rack
	output reg fe_chan_hi_ff, // Pulsar channels 4-7
	output reg fe_stn_hi_ff, // Pulsar stations 10-19
	output reg fe_tape_junk_ff, // Tape validity of no interest
	input wire be_req, // Back read request
	input wire [3:0] backend_map_code, // Back mapping code
	input wire [10:0] backend_result_field, // Back result field
	input wire be_force_bank, // Disable automatic bank selection
	input wire be_bank_in, // Bank bit from back address
	output reg be_out_valid_ff, // Back answer valid
	output reg be_bank_ff, // Back bank bit
	output reg [2:0] backend_validity_accum_code_ff // Back looked-up code
);

	// Software registers
	reg [7:0] bank_pend_ff;
	reg [7:0] bank_act_ff;
	reg [7:0] clear_accumulate_ff;
	reg [13:0] tbl_addr_ff;
	wire [1:0] tbl_sel;
	wire tbl_we;
	wire [10:0] tbl_idx;

	// Front pipeline stage one
	reg s1_valid_ff;
	reg [7:0] s1_result_ff;
	reg [2:0] s1_array_ff;
	reg [7:0] s1_baseline_ff;
	wire [6:0] bl_q;

	// Front pipeline stage two
	reg s2_valid_ff;
	reg [3:0] s2_map_ff;
	reg [2:0] s2_code_ff;
	reg [7:0] s2_result_ff;
	reg [2:0] s2_array_ff;
	reg [7:0] s2_baseline_ff;
	wire [2:0] fv_q;
	reg [2:0] nxt_code;

	// Back pipeline stage
	reg b1_valid_ff;
	reg [3:0] b1_map_ff;
	reg b1_force_ff;
	reg b1_bank_in_ff;
	wire [2:0] bv_q;
	reg nxt_be_bank;

	assign tbl_sel = tbl_addr_ff[`VBS_TA_SEL_MSB:`VBS_TA_SEL_LSB];
	assign tbl_idx = tbl_addr_ff[`VBS_TA_IDX_MSB:0];
	assign tbl_we = reg_wr && (reg_addr == `VBS_REG_TBL_DATA);

	// Baseline table: map code and accumulation code per baseline
	vbs_lut #(
		.AW(`VBS_BL_AW),
		.DW(`VBS_BL_DW)
	) u_bl_lut (
		.clock(clock),
		.sys_rst(sys_rst),
		.wr_en(tbl_we && (tbl_sel == `VBS_TBL_BASELINE)), // [R24]
		.wr_idx(tbl_idx[`VBS_BL_AW-1:0]),
		.wr_data(reg_wdata[`VBS_BL_DW-1:0]),
		.rd_idx(fe_baseline),
		.rd_data_ff(bl_q)
	);

	// Front validity table, tape half then pulsar half
	vbs_lut #(
		.AW(`VBS_FV_AW),
		.DW(`VBS_CODE_W)
	) u_fv_lut (
		.clock(clock),
		.sys_rst(sys_rst),
		.wr_en(tbl_we && (tbl_sel == `VBS_TBL_FRONT)), // [R6] [R24]
		.wr_idx(tbl_idx[`VBS_FV_AW-1:0]),
		.wr_data(reg_wdata[`VBS_CODE_W-1:0]),
		.rd_idx({bl_q[`VBS_BL_MAP_LSB], s1_result_ff}), // [R3] [R4] [R5]
		.rd_data_ff(fv_q)
	);

	// Back validity table, 2K deep
	vbs_lut #(
		.AW(`VBS_BV_AW),
		.DW(`VBS_CODE_W)
	) u_bv_lut (
		.clock(clock),
		.sys_rst(sys_rst),
		.wr_en(tbl_we && (tbl_sel == `VBS_TBL_BACK)), // [R24]
		.wr_idx(tbl_idx),
		.wr_data(reg_wdata[`VBS_CODE_W-1:0]),
		.rd_idx({backend_map_code[`VBS_MAP_KIND_BIT], backend_result_field[10:1]}), // [R8]
		.rd_data_ff(bv_q)
	);

	// Register writes and table index auto-increment
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bank_pend_ff <= `VBS_RST_BANK;
			tbl_addr_ff <= `VBS_RST_TA;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `VBS_REG_BANK_PEND)
				bank_pend_ff <= reg_wdata[7:0];
			if (reg_addr == `VBS_REG_TBL_ADDR)
				tbl_addr_ff <= reg_wdata[13:0];
			if (tbl_we)
				tbl_addr_ff <= {tbl_sel, 1'b0, tbl_idx + 11'h001};
		end
	end

	// Bank switch at interval start; clear-accumulate for switched codes
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bank_act_ff <= `VBS_RST_BANK;
			clear_accumulate_ff <= `VBS_RST_CLEAR_ACCUMULATE;
		end
		else if (interval_tick)
		begin
			bank_act_ff <= bank_pend_ff; // [R21]
			clear_accumulate_ff <= bank_pend_ff ^ bank_act_ff; // [R21]
		end
	end

	// Register read data, one cycle after the strobe
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata_ff <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`VBS_REG_BANK_PEND: reg_rdata_ff <= {8'h00, bank_pend_ff};
				`VBS_REG_BANK_ACT: reg_rdata_ff <= {8'h00, bank_act_ff};
				`VBS_REG_CLEAR_ACCUMULATE: reg_rdata_ff <= {8'h00, clear_accumulate_ff};
				`VBS_REG_TBL_ADDR: reg_rdata_ff <= {2'h0, tbl_addr_ff};
				`VBS_REG_STATUS: reg_rdata_ff <= {12'h000, fe_bank_ff,
					validity_accum_code_ff};
				default: reg_rdata_ff <= 16'h0000;
			endcase
		end
		else
			reg_rdata_ff <= 16'h0000;
	end

	// Front stage one: baseline table read in flight
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_valid_ff <= 1'b0;
			s1_result_ff <= 8'h00;
			s1_array_ff <= 3'h0;
			s1_baseline_ff <= 8'h00;
		end
		else
		begin
			s1_valid_ff <= fe_valid;
			s1_result_ff <= fe_result;
			s1_array_ff <= fe_array;
			s1_baseline_ff <= fe_baseline;
		end
	end

	// Front stage two: validity table read in flight
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s2_valid_ff <= 1'b0;
			s2_map_ff <= 4'h0;
			s2_code_ff <= 3'h0;
			s2_result_ff <= 8'h00;
			s2_array_ff <= 3'h0;
			s2_baseline_ff <= 8'h00;
		end
		else
		begin
			s2_valid_ff <= s1_valid_ff;
			s2_map_ff <= bl_q[`VBS_BL_MAP_MSB:`VBS_BL_MAP_LSB];
			s2_code_ff <= bl_q[`VBS_BL_CODE_MSB:0]; // [R1]
			s2_result_ff <= s1_result_ff;
			s2_array_ff <= s1_array_ff;
			s2_baseline_ff <= s1_baseline_ff;
		end
	end

	// Code choice: validity map codes use the second lookup
	always @*
	begin
		if (s2_map_ff[`VBS_MAP_VAL_BIT])
			nxt_code = fv_q; // [R2] [R7] [R23]
		else
			nxt_code = s2_code_ff; // [R1]
	end

	// Front answer: bank multiplexer and location decode
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fe_out_valid_ff <= 1'b0;
			fe_bank_ff <= 1'b0;
			fe_clear_accumulate_ff <= 1'b0;
			validity_accum_code_ff <= 3'h0;
			fe_loc_ff <= 11'h000;
			fe_validity_ff <= 1'b0;
			fe_pulsar_ff <= 1'b0;
			fe_rack_ff <= 2'h0;
			fe_entry_ff <= 1'b0;
			fe_chan_hi_ff <= 1'b0;
			fe_stn_hi_ff <= 1'b0;
			fe_tape_junk_ff <= 1'b0;
		end
		else
		begin
			fe_out_valid_ff <= s2_valid_ff;
			fe_bank_ff <= bank_act_ff[nxt_code]; // [R1] [R23] [R19]
			fe_clear_accumulate_ff <= clear_accumulate_ff[nxt_code]; // [R21]
			validity_accum_code_ff <= nxt_code;
			// Epoch n, eight arrays: locations 8n to 8n+7
			fe_loc_ff <= {s2_result_ff, s2_array_ff}; // [R13] [R14] [R15]
			fe_validity_ff <= s2_map_ff[`VBS_MAP_VAL_BIT];
			fe_pulsar_ff <= s2_map_ff[`VBS_MAP_VAL_BIT] &&
				s2_map_ff[`VBS_MAP_KIND_BIT]; // [R5]
			fe_rack_ff <= s2_array_ff[2:1]; // [R16]
			fe_entry_ff <= s2_array_ff[0]; // [R16]
			fe_chan_hi_ff <= s2_array_ff[2]; // [R17] [R18]
			fe_stn_hi_ff <= s2_array_ff[1]; // [R17] [R20]
			fe_tape_junk_ff <= (s2_baseline_ff == `VBS_BSLN_TAPE) &&
				(s2_result_ff > `VBS_TAPE_LAST); // [R7] [R14]
		end
	end

	// Back stage: validity table read in flight
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			b1_valid_ff <= 1'b0;
			b1_map_ff <= 4'h0;
			b1_force_ff <= 1'b0;
			b1_bank_in_ff <= 1'b0;
		end
		else
		begin
			b1_valid_ff <= be_req;
			b1_map_ff <= backend_map_code;
			b1_force_ff <= be_force_bank;
			b1_bank_in_ff <= be_bank_in;
		end
	end

	// Back bank: forced bit wins, else validity lookup, else address bit
	always @*
	begin
		if (b1_force_ff)
			nxt_be_bank = b1_bank_in_ff; // [R9] [R22]
		else if (b1_map_ff[`VBS_MAP_VAL_BIT])
			nxt_be_bank = bank_act_ff[bv_q]; // [R10] [R11] [R23]
		else
			nxt_be_bank = b1_bank_in_ff;
	end

	// Back answer
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			be_out_valid_ff <= 1'b0;
			be_bank_ff <= 1'b0;
			backend_validity_accum_code_ff <= 3'h0;
		end
		else
		begin
			be_out_valid_ff <= b1_valid_ff;
			be_bank_ff <= nxt_be_bank;
			backend_validity_accum_code_ff <= bv_q;
		end
	end

endmodule
`default_nettype wire

// *** pkg/vbs_defs.vh ***
`ifndef VBS_DEFS_VH
`define VBS_DEFS_VH

// Register word offsets
`define VBS_REG_BANK_PEND 4'h0
`define VBS_REG_BANK_ACT 4'h1
`define VBS_REG_CLEAR_ACCUMULATE 4'h2
`define VBS_REG_TBL_ADDR 4'h3
`define VBS_REG_TBL_DATA 4'h4
`define VBS_REG_STATUS 4'h5

// Table select values in the table address register
`define VBS_TBL_BASELINE 2'h0
`define VBS_TBL_FRONT 2'h1
`define VBS_TBL_BACK 2'h2

// Table address register fields
`define VBS_TA_IDX_MSB 10
`define VBS_TA_SEL_LSB 12
`define VBS_TA_SEL_MSB 13

// Baseline table entry fields: {map code, accumulation code}
`define VBS_BL_MAP_MSB 6
`define VBS_BL_MAP_LSB 3
`define VBS_BL_CODE_MSB 2

// Mapping code bits
`define VBS_MAP_VAL_BIT 3
`define VBS_MAP_KIND_BIT 0

// Table geometry
`define VBS_BL_AW 8
`define VBS_BL_DW 7
`define VBS_FV_AW 9
`define VBS_BV_AW 11
`define VBS_CODE_W 3

// Artificial baselines and tape limit
`define VBS_BSLN_TAPE 8'hD2
`define VBS_TAPE_LAST 8'hD1

// Reset values
`define VBS_RST_BANK 8'h00
`define VBS_RST_CLEAR_ACCUMULATE 8'h00
`define VBS_RST_TA 14'h0000

`endif

// *** src/vbs_lut.v ***
`timescale 1ns/1ps
`default_nettype none

// Flip-flop lookup table, one write port, one registered read port
module vbs_lut #(
	parameter AW = 8,
	parameter DW = 3
) (
	input wire clock, // System clock
	input wire sys_rst, // Asynchronous reset, active high
	input wire wr_en, // Write strobe
	input wire [AW-1:0] wr_idx, // Write index
	input wire [DW-1:0] wr_data, // Write data
	input wire [AW-1:0] rd_idx, // Read index
	output reg [DW-1:0] rd_data_ff // Read data, one cycle after index
);

	reg [DW-1:0] mem_ff [0:(1<<AW)-1];

	// Table storage, loaded by software
	always @(posedge clock)
	begin
		if (wr_en)
			mem_ff[wr_idx] <= wr_data;
	end

	// Registered read
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			rd_data_ff <= {DW{1'b0}};
		else
			rd_data_ff <= mem_ff[rd_idx];
	end

endmodule
`default_nettype wire

// *** dv/vbs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level timing and field checks
module vbs_chk (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Reset
	input wire logic reg_rd, // Read strobe
	input wire logic [15:0] reg_rdata_ff, // Read data
	input wire logic fe_valid, // Front request
	input wire logic [7:0] fe_baseline, // Baseline
	input wire logic [7:0] fe_result, // Result
	input wire logic [2:0] fe_array, // Array
	input wire logic fe_out_valid_ff, // Front answer
	input wire logic [10:0] fe_loc_ff, // Location
	input wire logic fe_validity_ff, // Validity
	input wire logic fe_pulsar_ff, // Pulsar
	input wire logic [1:0] fe_rack_ff, // Rack
	input wire logic fe_entry_ff, // Entry
	input wire logic fe_chan_hi_ff, // Channel half
	input wire logic fe_stn_hi_ff, // Station half
	input wire logic fe_tape_junk_ff, // Junk tape
	input wire logic be_req, // Back request
	input wire logic [3:0] backend_map_code, // Back map
	input wire logic be_force_bank, // Force
	input wire logic be_bank_in, // Bank in
	input wire logic be_out_valid_ff, // Back answer
	input wire logic be_bank_ff // Back bank
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Pipeline latencies
	fe_lat_a: assert property (fe_valid |-> ##3 fe_out_valid_ff) else $error("front late");
	fe_cause_a: assert property (fe_out_valid_ff |-> $past(fe_valid, 3)) else $error("front extra");
	be_lat_a: assert property (be_req |-> ##2 be_out_valid_ff) else $error("back late");
	// Back bank override and pass-through
	be_force_a: assert property (be_out_valid_ff && $past(be_force_bank, 2)
		|-> be_bank_ff == $past(be_bank_in, 2)) else $error("force ignored");
	be_pass_a: assert property (be_out_valid_ff && $past(backend_map_code, 2) < 4'h8
		|-> be_bank_ff == $past(be_bank_in, 2)) else $error("bank in lost");
	// Front fields
	fe_loc_a: assert property (fe_out_valid_ff |-> fe_loc_ff
		== {$past(fe_result, 3), $past(fe_array, 3)}) else $error("bad loc");
	fe_junk_a: assert property (fe_out_valid_ff |-> fe_tape_junk_ff == ($past(fe_baseline, 3)
		== 8'hD2 && $past(fe_result, 3) > 8'hD1)) else $error("bad junk");
	fe_rack_a: assert property (fe_out_valid_ff && fe_pulsar_ff
		|-> {fe_rack_ff, fe_entry_ff} == $past(fe_array, 3)) else $error("bad rack");
	fe_chan_a: assert property (fe_pulsar_ff |-> fe_chan_hi_ff == fe_rack_ff[1]
		&& fe_stn_hi_ff == fe_rack_ff[0]) else $error("bad half");
	pul_val_a: assert property (fe_pulsar_ff |-> fe_validity_ff) else $error("bad kind");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0000) else $error("rd idle");
	// Main scenarios seen
	cover property (fe_out_valid_ff && fe_pulsar_ff);
	cover property (fe_out_valid_ff && fe_tape_junk_ff);
	cover property (be_out_valid_ff && $past(be_force_bank, 2));
endmodule
bind vbs_top vbs_chk u_chk (.clock, .sys_rst, .reg_rd, .reg_rdata_ff, .fe_valid, .fe_baseline,
	.fe_result, .fe_array, .fe_out_valid_ff, .fe_loc_ff, .fe_validity_ff, .fe_pulsar_ff,
	.fe_rack_ff, .fe_entry_ff, .fe_chan_hi_ff, .fe_stn_hi_ff, .fe_tape_junk_ff, .be_req,
	.backend_map_code, .be_force_bank, .be_bank_in, .be_out_valid_ff, .be_bank_ff);
`default_nettype wire

// *** dv/vbs_mac_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// Result source standing in for the accumulate cards
module vbs_mac_src (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Reset
	input wire logic go, // Start
	input wire logic sw, // Sweep epoch
	input wire logic [7:0] pb, // Single baseline
	input wire logic [7:0] pr, // Epoch number
	input wire logic [2:0] pa, // Single array
	output var logic fe_valid_ff, // Present
	output var logic [7:0] fe_baseline_ff, // Baseline
	output var logic [7:0] fe_result_ff, // Result
	output var logic [2:0] fe_array_ff // Array
);
	logic run_ff;
	// Sweep baselines 0-212, arrays 0-7, result is the epoch
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			run_ff <= 1'h0;
			fe_valid_ff <= 1'h0;
			fe_baseline_ff <= 8'h00;
			fe_result_ff <= 8'h00;
			fe_array_ff <= 3'h0;
		end
		else if (go)
		begin
			fe_valid_ff <= 1'h1;
			run_ff <= sw;
			fe_baseline_ff <= sw ? 8'h00 : pb;
			fe_result_ff <= pr;
			fe_array_ff <= sw ? 3'h0 : pa;
		end
		else if (run_ff && !(fe_baseline_ff == 8'hD4 && &fe_array_ff))
		begin
			fe_array_ff <= fe_array_ff + 3'h1;
			fe_baseline_ff <= fe_baseline_ff + {7'h00, &fe_array_ff};
		end
		else
		begin
			// Idle lines toggle so stale values are never seen
			run_ff <= 1'h0;
			fe_valid_ff <= 1'h0;
			fe_baseline_ff <= ~fe_baseline_ff;
			fe_result_ff <= ~fe_result_ff;
			fe_array_ff <= ~fe_array_ff;
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'h0;
	logic sys_rst = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'h0, reg_rd = 1'h0, interval_tick = 1'h0, be_req = 1'h0;
	logic be_force_bank = 1'h0, be_bank_in = 1'h0, go = 1'h0, sw = 1'h0;
	logic [3:0] backend_map_code = 4'h0;
	logic [10:0] backend_result_field = 11'h000;
	logic [7:0] pb = 8'h00, pr = 8'h00, act = 8'h00, clr = 8'h00;
	logic [2:0] pa = 3'h0;
	logic [15:0] n;
	int failures = 0, total_checks = 0;
	wire [15:0] reg_rdata_ff;
	wire [10:0] fe_loc_ff;
	wire [7:0] fe_baseline, fe_result;
	wire [2:0] fe_array, validity_accum_code_ff, backend_validity_accum_code_ff;
	wire [1:0] fe_rack_ff;
	wire fe_valid, fe_out_valid_ff, fe_bank_ff, fe_clear_accumulate_ff, fe_validity_ff;
	wire fe_pulsar_ff, fe_entry_ff, fe_chan_hi_ff, fe_stn_hi_ff, fe_tape_junk_ff;
	wire be_out_valid_ff, be_bank_ff;
	// Clock, 25 ns period
	always #12.5 clock = ~clock;
	vbs_mac_src u_src (.clock, .sys_rst, .go, .sw, .pb, .pr, .pa, .fe_valid_ff(fe_valid),
		.fe_baseline_ff(fe_baseline), .fe_result_ff(fe_result), .fe_array_ff(fe_array));
	vbs_top DUT (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
		.interval_tick, .fe_valid, .fe_baseline, .fe_result, .fe_array, .fe_out_valid_ff,
		.fe_bank_ff, .fe_clear_accumulate_ff, .validity_accum_code_ff, .fe_loc_ff,
		.fe_validity_ff, .fe_pulsar_ff, .fe_rack_ff, .fe_entry_ff, .fe_chan_hi_ff,
		.fe_stn_hi_ff, .fe_tape_junk_ff, .be_req, .backend_map_code, .backend_result_field,
		.be_force_bank, .be_bank_in, .be_out_valid_ff, .be_bank_ff,
		.backend_validity_accum_code_ff);
	task complete_run;
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [15:0] s, input [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
		@(posedge clock);
	endtask
	task rd(input [3:0] a, input [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata_ff, e);
		@(posedge clock);
	endtask
	task tick;
		interval_tick <= 1'h1;
		@(posedge clock);
		interval_tick <= 1'h0;
		@(posedge clock);
	endtask
	// Table entries: baseline, front validity, back validity
	function [6:0] ent(input [1:0] s, input [10:0] i);
		case (s)
			2'h0: ent = i < 11'h0D2 ? {4'h0, i[2:0]} : (i == 11'h0D2 ? 7'h40 : 7'h48);
			2'h1: ent = i < 11'h100 ? {4'h0, i[2:0] ^ 3'h5} : 7'h06;
			default: ent = i < 11'h400 ? {4'h0, i[4:2] ^ 3'h5} : 7'h06;
		endcase
	endfunction
	task t_load;
		for (int s = 0; s < 3; s++)
		begin
			wr(4'h3, {2'h0, s[1:0], 12'h000});
			// Table depths 256, 512 and 2048, so no entry wraps onto another
			for (int i = 0; i < (256 << (s + s[1])); i++)
				wr(4'h4, {9'h000, ent(s[1:0], i[10:0])});
		end
		// Index wrapped after the full back table, select kept
		rd(4'h3, 16'h2000);
	endtask
	task t_regs;
		rd(4'h0, 16'h0000);
		rd(4'h2, 16'h0000);
		rd(4'hF, 16'h0000);
		rd(4'h4, 16'h0000);
		wr(4'h0, 16'h00A5);
		rd(4'h1, 16'h0000);
		tick;
		rd(4'h1, 16'h00A5);
		wr(4'h0, 16'h003C);
		tick;
		rd(4'h1, 16'h003C);
		rd(4'h2, 16'h0099);
		act = 8'h3C;
		clr = 8'h99;
	endtask
	task fe(input [7:0] b, input [7:0] r, input [2:0] a, input [2:0] c);
		go <= 1'h1;
		sw <= 1'h0;
		pb <= b;
		pr <= r;
		pa <= a;
		@(posedge clock);
		go <= 1'h0;
		repeat (3) @(posedge clock);
		#1;
		chk(fe_out_valid_ff, 1'h1);
		chk(validity_accum_code_ff, c);
		chk(fe_bank_ff, act[c]);
		chk(fe_clear_accumulate_ff, clr[c]);
		chk({fe_validity_ff, fe_pulsar_ff}, {b > 8'hD1, b > 8'hD2});
		chk(fe_loc_ff, {r, a});
		chk(fe_tape_junk_ff, b == 8'hD2 && r > 8'hD1);
		if (b > 8'hD2)
			chk({fe_rack_ff, fe_entry_ff, fe_chan_hi_ff, fe_stn_hi_ff}, {a, a[2], a[1]});
		@(posedge clock);
	endtask
	task t_front;
		for (int i = 0; i < 8; i++)
			fe(i[7:0], 8'h01, i[2:0], i[2:0]);
		fe(8'hD2, 8'hD1, 3'h7, 3'h4);
		fe(8'hD2, 8'hE6, 3'h0, 3'h3);
		fe(8'hD3, 8'h05, 3'h5, 3'h6);
		fe(8'hD4, 8'hFF, 3'h2, 3'h6);
	endtask
	task be(input [3:0] m, input [10:0] res, input f, input bi, input [2:0] c, input e);
		be_req <= 1'h1;
		backend_map_code <= m;
		backend_result_field <= res;
		be_force_bank <= f;
		be_bank_in <= bi;
		@(posedge clock);
		be_req <= 1'h0;
		@(posedge clock);
		#1;
		chk(be_out_valid_ff, 1'h1);
		chk(be_bank_ff, e);
		if (m[3])
			chk(backend_validity_accum_code_ff, c);
		@(posedge clock);
	endtask
	task t_back;
		be(4'h8, 11'h68C, 1'h0, 1'h0, 3'h4, act[4]);
		be(4'h9, 11'h7FF, 1'h0, 1'h1, 3'h6, act[6]);
		be(4'hB, 11'h123, 1'h1, 1'h1, 3'h6, 1'h1);
		be(4'h2, 11'h010, 1'h0, 1'h1, 3'h0, 1'h1);
	endtask
	task t_sweep;
		go <= 1'h1;
		sw <= 1'h1;
		pr <= 8'hD1;
		@(posedge clock);
		go <= 1'h0;
		n = 16'h0000;
		repeat (1720)
		begin
			@(posedge clock);
			#1;
			n = n + fe_out_valid_ff;
		end
		@(posedge clock);
		chk(n, 16'h06A8);
	endtask
	// Main sequence
	initial
	begin
		sys_rst <= 1'h1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'h0;
		t_regs;
		t_load;
		t_front;
		t_back;
		t_sweep;
		complete_run;
	end
	// Watchdog
	initial
	begin
		repeat (30000) @(posedge clock);
		failures++;
		complete_run;
	end
endmodule
`default_nettype wire
